/* stb_pkg.sv */
`default_nettype none
package stb_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SENSE_ONE_CONTROL_OFS = 8'h5d;
  localparam logic [7:0] SENSE_TWO_CONTROL_OFS = 8'h5e;
  localparam logic [7:0] SENSE_STATUS_OFS      = 8'h5f;  // event readback, write 1 to clear

  // ----------------------------------------------------------------
  // field layout of a control register
  // ----------------------------------------------------------------
  localparam int unsigned POWER_DOWN_BIT = 6;
  localparam int unsigned THRESHOLD_LSB  = 2;
  localparam int unsigned THRESHOLD_W    = 3;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic                   POWER_DOWN_RST = 1'b1;
  localparam logic [THRESHOLD_W-1:0] THRESHOLD_RST  = 3'h3;  // 525 mV level
  localparam logic [7:0]             RDATA_RST      = 8'h00;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHANNELS = 2;
  localparam int unsigned SYNC_STAGES  = 2;

  // register access as seen behind the serial configuration port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } stb_reg_req_t;

  // per-channel settings handed to the analog comparator
  typedef struct packed {
    logic                   power_down;
    logic [THRESHOLD_W-1:0] threshold;
  } stb_chan_cfg_t;

endpackage : stb_pkg
`default_nettype wire

/* stb_sense_ctrl.sv */
`default_nettype none

module stb_sense_ctrl #(
  parameter int unsigned NUM_CH = stb_pkg::NUM_CHANNELS,
  parameter int unsigned STAGES = stb_pkg::SYNC_STAGES
) (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire stb_pkg::stb_reg_req_t REG_REQ,
  output logic [7:0]                 REG_RDATA,
  input  wire logic [NUM_CH-1:0]     COMPARATOR_ABOVE,
  output stb_pkg::stb_chan_cfg_t     SENSE_ONE_CFG,
  output stb_pkg::stb_chan_cfg_t     SENSE_TWO_CFG,
  output logic [NUM_CH-1:0]          SHORT_TO_BATTERY_FLAGS,
  output logic                       INTERRUPT_REQUEST_OUT_N
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the register map holds exactly two control registers
  if (NUM_CH != 2) begin : g_bad_ch
    $error("stb_sense_ctrl supports exactly two sense channels");
  end
  if (STAGES < 2) begin : g_bad_stages
    $error("stb_sense_ctrl needs at least two synchroniser stages");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    stb_pkg::stb_chan_cfg_t [NUM_CH-1:0] cfg;
    logic [NUM_CH-1:0][STAGES-1:0]       pd_hist;
    logic [NUM_CH-1:0]                   flag;
    logic [7:0]                          rdata;
    logic                                irq_n;
  } stb_state_t;

  stb_state_t        state_reg;
  stb_state_t        state_next;
  logic [NUM_CH-1:0] above_sync;
  logic [NUM_CH-1:0] ctrl_sel;
  logic              status_sel;
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] clr;

  // ----------------------------------------------------------------
  // comparator synchronisation
  // ----------------------------------------------------------------
  // comparator outputs are analog and unrelated to CLK
  stb_sync #(
    .WIDTH  (NUM_CH),
    .STAGES (STAGES)
  ) u_sync (
    .clk      (CLK),
    .rst      (RST),
    .ce       (CE),
    .async_in (COMPARATOR_ABOVE),
    .sync_out (above_sync)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign ctrl_sel[0] = (REG_REQ.addr == stb_pkg::SENSE_ONE_CONTROL_OFS);
  assign ctrl_sel[1] = (REG_REQ.addr == stb_pkg::SENSE_TWO_CONTROL_OFS);
  assign status_sel  = (REG_REQ.addr == stb_pkg::SENSE_STATUS_OFS);

  // ----------------------------------------------------------------
  // per-channel event qualification and clear
  // ----------------------------------------------------------------
  // a powered-down slicer gives meaningless output, so it is masked; the mask is held
  // until the synchroniser has flushed samples taken while the channel was still down
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign hit[c] = above_sync[c] & ~state_reg.cfg[c].power_down &
                    ~(|state_reg.pd_hist[c]);
    assign clr[c] = REG_REQ.wr & status_sel & REG_REQ.wdata[c];
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (CE) begin
      // control writes; undefined bits are not stored
      for (int c = 0; c < NUM_CH; c++) begin
        if (REG_REQ.wr && ctrl_sel[c]) begin
          state_next.cfg[c].power_down = REG_REQ.wdata[stb_pkg::POWER_DOWN_BIT];
          state_next.cfg[c].threshold  =
            REG_REQ.wdata[stb_pkg::THRESHOLD_LSB +: stb_pkg::THRESHOLD_W];
        end
      end
      // power-down history, one entry per synchroniser stage
      for (int c = 0; c < NUM_CH; c++) begin
        state_next.pd_hist[c] = {state_reg.pd_hist[c][STAGES-2:0], state_reg.cfg[c].power_down};
      end
      // sticky flags: a new event in the clearing cycle keeps the flag set
      state_next.flag = (state_reg.flag & ~clr) | hit;
      // interrupt follows the flags, low while any is set
      state_next.irq_n = ~(|state_next.flag);
      // read data is registered, one cycle after the request
      if (REG_REQ.rd) begin
        state_next.rdata = 8'h00;
        for (int c = 0; c < NUM_CH; c++) begin
          if (ctrl_sel[c]) begin
            state_next.rdata[stb_pkg::POWER_DOWN_BIT] = state_reg.cfg[c].power_down;
            state_next.rdata[stb_pkg::THRESHOLD_LSB +: stb_pkg::THRESHOLD_W] = state_reg.cfg[c].threshold;
          end
        end
        if (status_sel) begin
          state_next.rdata[NUM_CH-1:0] = state_reg.flag;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // channels come up powered down so nothing fires before setup
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int c = 0; c < NUM_CH; c++) begin
        state_reg.cfg[c].power_down <= stb_pkg::POWER_DOWN_RST;
        state_reg.cfg[c].threshold  <= stb_pkg::THRESHOLD_RST;
      end
      state_reg.pd_hist <= '1;
      state_reg.flag  <= '0;
      state_reg.rdata <= stb_pkg::RDATA_RST;
      state_reg.irq_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  // the threshold is only meaningful once power_down is cleared by software
  assign SENSE_ONE_CFG           = state_reg.cfg[0];
  assign SENSE_TWO_CFG           = state_reg.cfg[1];
  assign SHORT_TO_BATTERY_FLAGS  = state_reg.flag;
  assign INTERRUPT_REQUEST_OUT_N = state_reg.irq_n;
  assign REG_RDATA               = state_reg.rdata;

endmodule : stb_sense_ctrl
`default_nettype wire

/* stb_sense_ctrl_assertions.sv */
`default_nettype none
// --------------------------------
// port checker for sense control
// --------------------------------
module stb_sense_ctrl_assertions #(
  parameter int unsigned NUM_CH = 2,
  parameter int unsigned STAGES = 2
) (
  input wire logic                   CLK,
  input wire logic                   RST,
  input wire logic                   CE,
  input wire stb_pkg::stb_reg_req_t  REG_REQ,
  input wire logic [7:0]             REG_RDATA,
  input wire logic [NUM_CH-1:0]      COMPARATOR_ABOVE,
  input wire stb_pkg::stb_chan_cfg_t SENSE_ONE_CFG,
  input wire stb_pkg::stb_chan_cfg_t SENSE_TWO_CFG,
  input wire logic [NUM_CH-1:0]      SHORT_TO_BATTERY_FLAGS,
  input wire logic                   INTERRUPT_REQUEST_OUT_N
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // control writes taken under CE, status clear of bit 0 with or without CE; the event window of four assumes two synchroniser stages
  wire w1 = CE && REG_REQ.wr && REG_REQ.addr == 8'h5d;
  wire w2 = CE && REG_REQ.wr && REG_REQ.addr == 8'h5e;
  wire clr = REG_REQ.wr && REG_REQ.addr == 8'h5f && REG_REQ.wdata[0];
  pd_one_a: assert property (w1 |=> SENSE_ONE_CFG.power_down == $past(REG_REQ.wdata[6]))
    else $error("ch1 power bit");
  lvl_one_a: assert property (w1 |=> SENSE_ONE_CFG.threshold == $past(REG_REQ.wdata[4:2]))
    else $error("ch1 level");
  pd_two_a: assert property (w2 |=> SENSE_TWO_CFG.power_down == $past(REG_REQ.wdata[6]))
    else $error("ch2 power bit");
  lvl_two_a: assert property (w2 |=> SENSE_TWO_CFG.threshold == $past(REG_REQ.wdata[4:2]))
    else $error("ch2 level");
  ev_one_a: assert property ((CE && !SENSE_ONE_CFG.power_down && COMPARATOR_ABOVE[0]) [*4]
    |=> SHORT_TO_BATTERY_FLAGS[0]) else $error("ch1 event missed");
  ev_two_a: assert property ((CE && !SENSE_TWO_CFG.power_down && COMPARATOR_ABOVE[1]) [*4]
    |=> SHORT_TO_BATTERY_FLAGS[1]) else $error("ch2 event missed");
  irq_level_a: assert property (INTERRUPT_REQUEST_OUT_N == !(|SHORT_TO_BATTERY_FLAGS))
    else $error("irq mismatch");
  stat_read_a: assert property (CE && REG_REQ.rd && REG_REQ.addr == 8'h5f
    |=> REG_RDATA == {6'h00, $past(SHORT_TO_BATTERY_FLAGS)}) else $error("status read");
  pd_ignore_a: assert property ($rose(SHORT_TO_BATTERY_FLAGS[0]) |-> !$past(SENSE_ONE_CFG.power_down))
    else $error("event while down");
  sticky_a: assert property (SHORT_TO_BATTERY_FLAGS[0] && !clr |=> SHORT_TO_BATTERY_FLAGS[0])
    else $error("flag lost");
endmodule // stb_sense_ctrl_assertions
bind stb_sense_ctrl stb_sense_ctrl_assertions #(.NUM_CH(NUM_CH), .STAGES(STAGES)) u_chk (.CLK(CLK), .RST(RST),
  .CE(CE), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .COMPARATOR_ABOVE(COMPARATOR_ABOVE),
  .SENSE_ONE_CFG(SENSE_ONE_CFG), .SENSE_TWO_CFG(SENSE_TWO_CFG), .SHORT_TO_BATTERY_FLAGS(SHORT_TO_BATTERY_FLAGS),
  .INTERRUPT_REQUEST_OUT_N(INTERRUPT_REQUEST_OUT_N));
`default_nettype wire

/* stb_sense_model.sv */
`default_nettype none
// two divided connector voltages in mV against the slicers
module stb_sense_model (
  input  wire logic [23:0]                  mv,
  input  wire stb_pkg::stb_chan_cfg_t [1:0] cfg,
  output var  logic [1:0]                   above
);
  timeunit 1ns;
  timeprecision 100ps;
  // a powered-down slicer output is untrustworthy: it reads high so the block must ignore it
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      above[i] = cfg[i].power_down | (mv[i*12 +: 12] > 12'h04b + 12'h096 * cfg[i].threshold);
    end
  end
endmodule // stb_sense_model
`default_nettype wire

/* stb_sync.sv */
`default_nettype none
// ----------------------------------------------------------------
// multi-bit level synchroniser, one chain per bit
// ----------------------------------------------------------------
module stb_sync #(
  parameter int unsigned WIDTH  = 2,
  parameter int unsigned STAGES = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (STAGES < 2) begin : g_bad_stages
    $error("stb_sync needs at least two stages");
  end

  typedef struct packed {
    logic [WIDTH-1:0][STAGES-1:0] chain;
  } stb_sync_state_t;

  stb_sync_state_t state_reg;
  stb_sync_state_t state_next;

  // shift each bit along its own chain; only the next stage reads stage 0
  always_comb begin
    state_next = state_reg;
    if (ce) begin
      for (int b = 0; b < WIDTH; b++) begin
        state_next.chain[b] = {state_reg.chain[b][STAGES-2:0], async_in[b]};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  for (genvar b = 0; b < WIDTH; b++) begin : g_out
    assign sync_out[b] = state_reg.chain[b][STAGES-1];
  end

endmodule : stb_sync
`default_nettype wire

/* tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   ce = 1'b1;
  stb_pkg::stb_reg_req_t  req = '0;
  logic [23:0]            mv = '0;
  logic [1:0]             above;
  logic [7:0]             rdata;
  stb_pkg::stb_chan_cfg_t cfg1;
  stb_pkg::stb_chan_cfg_t cfg2;
  logic [1:0]             flags;
  logic                   irq_n;
  int                     mismatches = 0;
  int                     tests_run = 0;
  stb_sense_ctrl dut (.CLK(clk), .RST(rst), .CE(ce), .REG_REQ(req), .REG_RDATA(rdata), .COMPARATOR_ABOVE(above),
    .SENSE_ONE_CFG(cfg1), .SENSE_TWO_CFG(cfg2), .SHORT_TO_BATTERY_FLAGS(flags), .INTERRUPT_REQUEST_OUT_N(irq_n));
  stb_sense_model model (.mv(mv), .cfg({cfg2, cfg1}), .above(above));
  initial begin
    forever #5 clk = ~clk;
  end
  // ------------------------
  // bus cycles and compare
  // ------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk);
    #1 req = '0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    #1 req = '0;
    chk(rdata, e);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // defaults, refusal of unmapped and disabled requests, garbage while powered down
  task automatic s_reset();
    mv = 24'hfff_fff;
    rc(8'h5d, 8'h4c);
    rc(8'h5e, 8'h4c);
    rc(8'h60, 8'h00);
    ce = 1'b0;
    wr(8'h5d, 8'h00);
    ce = 1'b1;
    rc(8'h5d, 8'h4c);
    rc(8'h5f, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    mv = '0;
  endtask
  // every level on both channels: equal stays quiet, one mV more fires and sticks
  task automatic s_levels();
    logic [11:0] lv;
    logic [7:0]  a;
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 8; c++) begin
        lv = 12'h04b + 12'h096 * c[11:0];
        a = 8'h5d + ch[7:0];
        wr(a, {3'h0, c[2:0], 2'h0});
        repeat (5) @(posedge clk);
        wr(8'h5f, 8'h03);
        mv[ch*12 +: 12] = lv;
        rc(a, {3'h0, c[2:0], 2'h0});
        chk({4'h0, ch ? cfg2 : cfg1}, {5'h00, c[2:0]});
        repeat (5) @(posedge clk);
        rc(8'h5f, 8'h00);
        mv[ch*12 +: 12] = lv + 12'h001;
        repeat (5) @(posedge clk);
        #1 chk({7'h00, irq_n}, 8'h00);
        mv = '0;
        rc(8'h5f, 8'h01 << ch);
        wr(8'h5f, 8'h01 << ch);
        rc(8'h5f, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        wr(a, 8'h4c);
      end
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    s_reset();
    s_levels();
    print_verdict();
  end
  // tests need about 500 cycles; a hundred times that marks a hang
  initial begin
    #500000;
    mismatches++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
